// ===== switch_system_control_regs.sv
// System control register bank with its decoded controls toward the switch core.
// Assumes a plain register port and a core that samples the control outputs.
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module switch_system_control_regs
   import sysctl_pkg::*;
(
   // Clock and reset.
   input wire logic CLK,
   input wire logic RESET_N,
   // Register port.
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [DATA_W-1:0] RDATA,
   // Core status feeding the controls.
   input wire logic RX_CLK_LEVEL,
   input wire logic TX_CLK_LEVEL,
   input wire logic FRAME_IS_BROADCAST,
   input wire logic FRAME_IS_MULTICAST,
   input wire logic CORE_IRQ,
   // Controls toward the switch core.
   output logic [7:0] DROP_SCHEMES,
   output logic RX_CLK_EFFECTIVE,
   output logic RX_CLK_STOPPED,
   output logic FLOOD_COUNT_INC,
   output logic CRC_CHECK_ON,
   output logic BACKOFF_ON,
   output logic LEGACY_GUARD_ON,
   output logic NATIVE_GUARD_ON,
   output logic [1:0] FLOOD_LIMIT_LEVEL,
   output logic [PORT_COUNT-1:0] HOST_PORT_MASK,
   output logic HOST_PRESENT,
   output logic TAG_RX_ON,
   output logic TAG_TX_ON,
   output logic TAG_PAUSE_ON,
   output logic [10:0] MAX_FRAME_LEN,
   output logic TAG_VLAN_ON,
   output logic MAC_CLONE_ON,
   output logic IRQ_PIN
);
   ////////////////////////////////////////////////////////////////////////////////
   // Register storage and read port.
   logic [DATA_W-1:0] sysctl_two;
   logic [DATA_W-1:0] sysctl_three;
   logic [DATA_W-1:0] next_sysctl_two;
   logic [DATA_W-1:0] next_sysctl_three;
   logic [DATA_W-1:0] next_rdata;

   always_comb begin
      next_sysctl_two = sysctl_two;
      next_sysctl_three = sysctl_three;
      next_rdata = 16'h0000;
      // Every bit is plain read/write, including the inert aging and test bits.
      if (WR && ADDR == SYSCTL_TWO_ADDR) begin
         next_sysctl_two = WDATA;
      end
      if (WR && ADDR == SYSCTL_THREE_ADDR) begin
         next_sysctl_three = WDATA;
      end
      // Unmapped addresses read as zero.
      if (RD) begin
         if (ADDR == SYSCTL_TWO_ADDR) begin
            next_rdata = sysctl_two;
         end else if (ADDR == SYSCTL_THREE_ADDR) begin
            next_rdata = sysctl_three;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         sysctl_two <= SYSCTL_TWO_RESET;
         sysctl_three <= SYSCTL_THREE_RESET;
         RDATA <= 16'h0000;
      end else begin
         sysctl_two <= next_sysctl_two;
         sysctl_three <= next_sysctl_three;
         RDATA <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Field extraction.
   logic [2:0] host_port_select;
   logic [2:0] frame_length_limit;
   logic flood_scheme_select;
   logic host_tag_tx_enable;
   logic irq_level_invert;

   assign host_port_select = sysctl_three[HOST_PORT_SELECT_LSB +: 3];
   assign frame_length_limit = sysctl_three[FRAME_LENGTH_LIMIT_LSB +: 3];
   assign flood_scheme_select = sysctl_three[FLOOD_SCHEME_SELECT_BIT];
   assign host_tag_tx_enable = sysctl_three[HOST_TAG_TX_ENABLE_BIT];
   assign irq_level_invert = sysctl_three[IRQ_LEVEL_INVERT_BIT];

   ////////////////////////////////////////////////////////////////////////////////
   // Receive clock fallback.
   logic rx_stopped;
   logic rx_out;

   rx_clock_fallback_sel #(
      .STALL_CYCLES(RX_CLOCK_STALL_CYCLES)
   ) u_rx_fallback (
      .clk(CLK),
      .reset_n(RESET_N),
      .fallback_on(sysctl_two[RX_CLOCK_FALLBACK_BIT]),
      .rx_level(RX_CLK_LEVEL),
      .tx_level(TX_CLK_LEVEL),
      .rx_stopped(rx_stopped),
      .rx_out(rx_out)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Decoded controls.
   logic [7:0] next_drop_schemes;
   logic next_flood_count_inc;
   logic next_crc_check_on;
   logic next_backoff_on;
   logic next_legacy_guard_on;
   logic next_native_guard_on;
   logic [1:0] next_flood_limit_level;
   logic [PORT_COUNT-1:0] next_host_port_mask;
   logic next_host_present;
   logic next_tag_rx_on;
   logic next_tag_tx_on;
   logic next_tag_pause_on;
   logic [10:0] next_max_frame_len;
   logic next_tag_vlan_on;
   logic next_mac_clone_on;
   logic next_irq_pin;

   // Queue 3 in the top pair down to queue 0 in the bottom pair.
   assign next_drop_schemes = sysctl_two[DROP_SCHEME_LSB +: 8];

   genvar p;
   generate
      for (p = 0; p < PORT_COUNT; p++) begin : g_host_port
         assign next_host_port_mask[p] = (host_port_select == 3'(p));
      end
   endgenerate

   always_comb begin
      // Broadcast always counts; multicast only when enabled.
      next_flood_count_inc = FRAME_IS_BROADCAST ||
         (sysctl_two[MULTICAST_IN_FLOOD_COUNT_BIT] && FRAME_IS_MULTICAST);
      next_crc_check_on = !sysctl_two[FRAME_CHECK_OFF_BIT];
      next_backoff_on = !sysctl_two[BACKOFF_OFF_BIT];
      next_legacy_guard_on = !flood_scheme_select &&
         sysctl_two[FLOOD_GUARD_ENABLE_BIT];
      next_native_guard_on = flood_scheme_select;
      next_flood_limit_level = sysctl_two[FLOOD_LIMIT_LEVEL_LSB +: 2];
      // Code 110 is unassigned; the core sees no CPU port for it.
      next_host_present = (host_port_select != HOST_PORT_NONE) &&
         (host_port_select < 3'(PORT_COUNT));
      next_tag_rx_on = sysctl_three[HOST_TAG_RX_ENABLE_BIT];
      next_tag_tx_on = host_tag_tx_enable && next_host_present;
      next_tag_pause_on = next_tag_tx_on &&
         sysctl_three[TAG_ON_FLOW_FRAMES_BIT];
      unique case (frame_length_limit)
         3'b000: next_max_frame_len = FRAME_LEN_1518;
         3'b001: next_max_frame_len = FRAME_LEN_1536;
         3'b010: next_max_frame_len = FRAME_LEN_1664;
         3'b110: next_max_frame_len = FRAME_LEN_1522;
         default: next_max_frame_len = FRAME_LEN_1784;
      endcase
      next_tag_vlan_on = sysctl_three[VLAN_BY_TAG_BIT];
      next_mac_clone_on = sysctl_three[MAC_CLONING_ON_BIT];
      // Pin is active low unless inverted: idle level is the opposite polarity.
      next_irq_pin = irq_level_invert ? CORE_IRQ : !CORE_IRQ;
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         DROP_SCHEMES <= 8'h00;
         RX_CLK_EFFECTIVE <= 1'b0;
         RX_CLK_STOPPED <= 1'b0;
         FLOOD_COUNT_INC <= 1'b0;
         CRC_CHECK_ON <= 1'b1;
         BACKOFF_ON <= 1'b1;
         LEGACY_GUARD_ON <= 1'b0;
         NATIVE_GUARD_ON <= 1'b0;
         FLOOD_LIMIT_LEVEL <= 2'h0;
         HOST_PORT_MASK <= '0;
         HOST_PRESENT <= 1'b0;
         TAG_RX_ON <= 1'b0;
         TAG_TX_ON <= 1'b0;
         TAG_PAUSE_ON <= 1'b0;
         MAX_FRAME_LEN <= FRAME_LEN_1518;
         TAG_VLAN_ON <= 1'b0;
         MAC_CLONE_ON <= 1'b0;
         IRQ_PIN <= 1'b1;
      end else begin
         DROP_SCHEMES <= next_drop_schemes;
         RX_CLK_EFFECTIVE <= rx_out;
         RX_CLK_STOPPED <= rx_stopped;
         FLOOD_COUNT_INC <= next_flood_count_inc;
         CRC_CHECK_ON <= next_crc_check_on;
         BACKOFF_ON <= next_backoff_on;
         LEGACY_GUARD_ON <= next_legacy_guard_on;
         NATIVE_GUARD_ON <= next_native_guard_on;
         FLOOD_LIMIT_LEVEL <= next_flood_limit_level;
         HOST_PORT_MASK <= next_host_port_mask;
         HOST_PRESENT <= next_host_present;
         TAG_RX_ON <= next_tag_rx_on;
         TAG_TX_ON <= next_tag_tx_on;
         TAG_PAUSE_ON <= next_tag_pause_on;
         MAX_FRAME_LEN <= next_max_frame_len;
         TAG_VLAN_ON <= next_tag_vlan_on;
         MAC_CLONE_ON <= next_mac_clone_on;
         IRQ_PIN <= next_irq_pin;
      end
   end
endmodule
`default_nettype wire

// ===== sysctl_pkg.sv
// Constants and register layout for the switch system control register bank.
// Assumes a single 10 MHz clock and a plain address/strobe register port.
package sysctl_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam logic [ADDR_W-1:0] SYSCTL_TWO_ADDR = 8'h10;
   localparam logic [ADDR_W-1:0] SYSCTL_THREE_ADDR = 8'h11;
   localparam logic [DATA_W-1:0] SYSCTL_TWO_RESET = 16'h0040;
   localparam logic [DATA_W-1:0] SYSCTL_THREE_RESET = 16'hE300;
   // Control register two fields.
   localparam int DROP_SCHEME_LSB = 8;
   localparam int AGING_OFF_BIT = 7;
   localparam int RX_CLOCK_FALLBACK_BIT = 6;
   localparam int MULTICAST_IN_FLOOD_COUNT_BIT = 5;
   localparam int FRAME_CHECK_OFF_BIT = 4;
   localparam int BACKOFF_OFF_BIT = 3;
   localparam int FLOOD_GUARD_ENABLE_BIT = 2;
   localparam int FLOOD_LIMIT_LEVEL_LSB = 0;
   // Control register three fields.
   localparam int HOST_PORT_SELECT_LSB = 13;
   localparam int HOST_TAG_RX_ENABLE_BIT = 12;
   localparam int HOST_TAG_TX_ENABLE_BIT = 11;
   localparam int TAG_ON_FLOW_FRAMES_BIT = 10;
   localparam int FRAME_LENGTH_LIMIT_LSB = 7;
   localparam int FLOOD_SCHEME_SELECT_BIT = 6;
   localparam int VLAN_BY_TAG_BIT = 5;
   localparam int MAC_CLONING_ON_BIT = 4;
   localparam int QUEUE_TEST_OPTION_BIT = 3;
   localparam int IRQ_LEVEL_INVERT_BIT = 2;
   localparam int AGING_TIMER_LSB = 0;
   localparam logic [2:0] HOST_PORT_NONE = 3'h7;
   localparam int PORT_COUNT = 6;
   // Frame length limits in bytes.
   localparam logic [10:0] FRAME_LEN_1518 = 11'd1518;
   localparam logic [10:0] FRAME_LEN_1536 = 11'd1536;
   localparam logic [10:0] FRAME_LEN_1664 = 11'd1664;
   localparam logic [10:0] FRAME_LEN_1522 = 11'd1522;
   localparam logic [10:0] FRAME_LEN_1784 = 11'd1784;
   // Receive clock is declared stopped after this many system cycles with no edge.
   localparam int RX_CLOCK_STALL_CYCLES = 8;
endpackage

// ===== rx_clock_fallback_sel.sv
// Receive clock watchdog for the serial MAC interface.
// Assumes rx and tx clock levels are already synchronous samples of the system clock.
`timescale 1ns/1ns
`default_nettype none
module rx_clock_fallback_sel
   import sysctl_pkg::*;
#(
   parameter int STALL_CYCLES = RX_CLOCK_STALL_CYCLES
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic fallback_on,
   input wire logic rx_level,
   input wire logic tx_level,
   output logic rx_stopped,
   output logic rx_out
);
   // The idle counter is eight bits wide, so longer windows cannot be served.
   if (STALL_CYCLES < 2 || STALL_CYCLES > 255) begin : g_bad_stall
      $error("STALL_CYCLES out of range");
   end

   logic [7:0] idle_count;
   logic [7:0] next_idle_count;
   logic rx_prev;
   logic next_rx_prev;
   logic stopped;
   logic next_stopped;
   logic out_q;
   logic next_out_q;

   always_comb begin
      next_rx_prev = rx_level;
      next_idle_count = idle_count;
      next_stopped = stopped;
      if (rx_level != rx_prev) begin
         next_idle_count = 8'h00;
         next_stopped = 1'b0;
      end else if (idle_count == 8'(STALL_CYCLES - 1)) begin
         next_stopped = 1'b1;
      end else begin
         next_idle_count = idle_count + 8'h01;
      end
      // Substitution happens only while enabled and the receive clock is dead.
      next_out_q = (fallback_on && stopped) ? tx_level : rx_level;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         idle_count <= 8'h00;
         rx_prev <= 1'b0;
         stopped <= 1'b0;
         out_q <= 1'b0;
      end else begin
         idle_count <= next_idle_count;
         rx_prev <= next_rx_prev;
         stopped <= next_stopped;
         out_q <= next_out_q;
      end
   end

   assign rx_stopped = stopped;
   assign rx_out = out_q;
endmodule
`default_nettype wire

// ===== sysctl_props.sv
// Port-level checks for the system control register bank.
// Assumes one clock and the bench as the only register master.
`timescale 1ns/1ns
`default_nettype none
module sysctl_props
   import sysctl_pkg::*;
(
   // Clock, reset and register port.
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [DATA_W-1:0] WDATA,
   input wire logic WR,
   // Core status.
   input wire logic FRAME_IS_BROADCAST,
   input wire logic FRAME_IS_MULTICAST,
   input wire logic CORE_IRQ,
   // Controls.
   input wire logic [7:0] DROP_SCHEMES,
   input wire logic FLOOD_COUNT_INC,
   input wire logic CRC_CHECK_ON,
   input wire logic BACKOFF_ON,
   input wire logic LEGACY_GUARD_ON,
   input wire logic NATIVE_GUARD_ON,
   input wire logic [PORT_COUNT-1:0] HOST_PORT_MASK,
   input wire logic HOST_PRESENT,
   input wire logic TAG_TX_ON,
   input wire logic TAG_PAUSE_ON,
   input wire logic TAG_VLAN_ON,
   input wire logic MAC_CLONE_ON,
   input wire logic IRQ_PIN
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   ////////////////////////////////////////////////////////////////////////////////
   sequence wr2;
      WR && ADDR == SYSCTL_TWO_ADDR;
   endsequence
   sequence wr3;
      WR && ADDR == SYSCTL_THREE_ADDR;
   endsequence
   drop_map_a: assert property (wr2 |-> ##2 DROP_SCHEMES == $past(WDATA[15:8], 2))
      else $error("drop scheme output differs from written field");
   crc_backoff_a: assert property (wr2 |-> ##2 CRC_CHECK_ON != $past(WDATA[4], 2)
      && BACKOFF_ON != $past(WDATA[3], 2)) else $error("check or back-off enable wrong");
   host_port_a: assert property (wr3 |-> ##2 HOST_PRESENT == ($past(WDATA[15:13], 2) < 3'h6))
      else $error("host presence does not follow port field");
   mask_onehot_a: assert property ($onehot0(HOST_PORT_MASK) && (HOST_PORT_MASK != '0) == HOST_PRESENT)
      else $error("host port mask inconsistent");
   vlan_clone_a: assert property (wr3 |-> ##2 TAG_VLAN_ON == $past(WDATA[5], 2)
      && MAC_CLONE_ON == $past(WDATA[4], 2)) else $error("vlan or clone enable wrong");
   pause_tag_a: assert property (TAG_PAUSE_ON |-> TAG_TX_ON && HOST_PRESENT)
      else $error("pause tagging without tag transmit");
   guard_scheme_a: assert property (!(LEGACY_GUARD_ON && NATIVE_GUARD_ON))
      else $error("both storm schemes active");
   flood_count_a: assert property (FRAME_IS_BROADCAST || !FRAME_IS_MULTICAST
      |=> FLOOD_COUNT_INC == $past(FRAME_IS_BROADCAST)) else $error("storm count pulse wrong");
   irq_pol_a: assert property (wr3 |-> ##2 IRQ_PIN == ($past(CORE_IRQ) ^ !$past(WDATA[2], 2)))
      else $error("interrupt pin polarity wrong");
   cover property (wr3 ##0 WDATA[15:13] == HOST_PORT_NONE);
   cover property (TAG_PAUSE_ON);
   cover property (LEGACY_GUARD_ON);
endmodule
bind switch_system_control_regs sysctl_props chk_u (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .FRAME_IS_BROADCAST(FRAME_IS_BROADCAST),
   .FRAME_IS_MULTICAST(FRAME_IS_MULTICAST), .CORE_IRQ(CORE_IRQ), .DROP_SCHEMES(DROP_SCHEMES),
   .FLOOD_COUNT_INC(FLOOD_COUNT_INC), .CRC_CHECK_ON(CRC_CHECK_ON), .BACKOFF_ON(BACKOFF_ON),
   .LEGACY_GUARD_ON(LEGACY_GUARD_ON), .NATIVE_GUARD_ON(NATIVE_GUARD_ON),
   .HOST_PORT_MASK(HOST_PORT_MASK), .HOST_PRESENT(HOST_PRESENT), .TAG_TX_ON(TAG_TX_ON),
   .TAG_PAUSE_ON(TAG_PAUSE_ON), .TAG_VLAN_ON(TAG_VLAN_ON), .MAC_CLONE_ON(MAC_CLONE_ON),
   .IRQ_PIN(IRQ_PIN));
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the system control register bank.
// Assumes the bank alone, driven straight from this bench on one clock.
`timescale 1ns/1ns
`default_nettype none
module testbench
   import sysctl_pkg::*;
;
   logic CLK = 1'b0;
   logic RESET_N, WR, RD, RX_CLK_LEVEL, TX_CLK_LEVEL, FRAME_IS_BROADCAST, FRAME_IS_MULTICAST;
   logic CORE_IRQ, RX_CLK_EFFECTIVE, RX_CLK_STOPPED, FLOOD_COUNT_INC, CRC_CHECK_ON, BACKOFF_ON;
   logic LEGACY_GUARD_ON, NATIVE_GUARD_ON, HOST_PRESENT, TAG_RX_ON, TAG_TX_ON, TAG_PAUSE_ON;
   logic TAG_VLAN_ON, MAC_CLONE_ON, IRQ_PIN;
   logic [ADDR_W-1:0] ADDR;
   logic [DATA_W-1:0] WDATA, RDATA, c2, c3, d;
   logic [7:0] DROP_SCHEMES;
   logic [1:0] FLOOD_LIMIT_LEVEL;
   logic [5:0] HOST_PORT_MASK;
   logic [10:0] MAX_FRAME_LEN;
   logic [31:0] seed = 32'h24;
   logic [31:0] r;
   logic [39:0] dec;
   int errors = 0;
   int checks = 0;
   assign dec = {3'h0, DROP_SCHEMES, CRC_CHECK_ON, BACKOFF_ON, LEGACY_GUARD_ON, NATIVE_GUARD_ON,
      FLOOD_LIMIT_LEVEL, HOST_PORT_MASK, HOST_PRESENT, TAG_RX_ON, TAG_TX_ON, TAG_PAUSE_ON,
      MAX_FRAME_LEN, TAG_VLAN_ON, MAC_CLONE_ON};
   switch_system_control_regs dut_u (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .RX_CLK_LEVEL(RX_CLK_LEVEL), .TX_CLK_LEVEL(TX_CLK_LEVEL),
      .FRAME_IS_BROADCAST(FRAME_IS_BROADCAST), .FRAME_IS_MULTICAST(FRAME_IS_MULTICAST),
      .CORE_IRQ(CORE_IRQ), .DROP_SCHEMES(DROP_SCHEMES), .RX_CLK_EFFECTIVE(RX_CLK_EFFECTIVE),
      .RX_CLK_STOPPED(RX_CLK_STOPPED), .FLOOD_COUNT_INC(FLOOD_COUNT_INC),
      .CRC_CHECK_ON(CRC_CHECK_ON), .BACKOFF_ON(BACKOFF_ON), .LEGACY_GUARD_ON(LEGACY_GUARD_ON),
      .NATIVE_GUARD_ON(NATIVE_GUARD_ON), .FLOOD_LIMIT_LEVEL(FLOOD_LIMIT_LEVEL),
      .HOST_PORT_MASK(HOST_PORT_MASK), .HOST_PRESENT(HOST_PRESENT), .TAG_RX_ON(TAG_RX_ON),
      .TAG_TX_ON(TAG_TX_ON), .TAG_PAUSE_ON(TAG_PAUSE_ON), .MAX_FRAME_LEN(MAX_FRAME_LEN),
      .TAG_VLAN_ON(TAG_VLAN_ON), .MAC_CLONE_ON(MAC_CLONE_ON), .IRQ_PIN(IRQ_PIN));
   always #50 CLK = ~CLK;
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Host code 110 counts as no CPU, so tag transmit is off there as well.
   function automatic logic [39:0] exp_dec(logic [15:0] a, logic [15:0] b);
      logic p;
      logic [10:0] n;
      p = b[15:13] < 3'h6;
      case (b[9:7])
         3'h0: n = FRAME_LEN_1518;
         3'h1: n = FRAME_LEN_1536;
         3'h2: n = FRAME_LEN_1664;
         3'h6: n = FRAME_LEN_1522;
         default: n = FRAME_LEN_1784;
      endcase
      return {3'h0, a[15:8], !a[4], !a[3], a[2] & !b[6], b[6], a[1:0],
         p ? 6'(1 << b[15:13]) : 6'h0, p, b[12], b[11] & p, b[11] & p & b[10], n, b[5], b[4]};
   endfunction
   task automatic cmp(input logic [39:0] g, input logic [39:0] e);
      checks++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
      if (a == SYSCTL_TWO_ADDR) c2 = v;
      if (a == SYSCTL_THREE_ADDR) c3 = v;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 cmp(40'(RDATA), 40'(e));
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {RESET_N, WR, RD, RX_CLK_LEVEL, TX_CLK_LEVEL, FRAME_IS_BROADCAST} = '0;
      {FRAME_IS_MULTICAST, CORE_IRQ, ADDR, WDATA} = '0;
      c2 = SYSCTL_TWO_RESET;
      c3 = SYSCTL_THREE_RESET;
      repeat (4) @(posedge CLK);
      RESET_N <= 1'b1;
      rd(SYSCTL_TWO_ADDR, SYSCTL_TWO_RESET);
      rd(SYSCTL_THREE_ADDR, SYSCTL_THREE_RESET);
      rd(8'h12, 16'h0000);
      cmp(dec, exp_dec(c2, c3));
      for (int i = 0; i < 16; i++) begin
         d = 16'(rnd());
         d[9:7] = i[2:0];
         d[15:13] = i[2:0];
         wr(SYSCTL_THREE_ADDR, d);
         wr(SYSCTL_TWO_ADDR, 16'(rnd()));
         wr(8'h12, 16'(rnd()));
         rd(SYSCTL_THREE_ADDR, c3);
         rd(SYSCTL_TWO_ADDR, c2);
         cmp(dec, exp_dec(c2, c3));
         repeat (4) begin
            r = rnd();
            @(posedge CLK);
            FRAME_IS_BROADCAST <= r[0];
            FRAME_IS_MULTICAST <= r[1];
            CORE_IRQ <= r[2];
            @(posedge CLK);
            #1 cmp(40'({FLOOD_COUNT_INC, IRQ_PIN}), 40'({r[0] | r[1] & c2[5], r[2] ^ !c3[2]}));
         end
      end
      // Receive level held still long enough to be seen stopped, transmit held high.
      for (int f = 0; f < 2; f++) begin
         wr(SYSCTL_TWO_ADDR, (c2 & 16'hFFBF) | 16'(f << 6));
         RX_CLK_LEVEL <= 1'b0;
         TX_CLK_LEVEL <= 1'b1;
         repeat (12) @(posedge CLK);
         #1 cmp(40'({RX_CLK_STOPPED, RX_CLK_EFFECTIVE}), 40'({1'b1, f[0]}));
         repeat (4) begin
            @(posedge CLK);
            RX_CLK_LEVEL <= !RX_CLK_LEVEL;
         end
         repeat (2) @(posedge CLK);
         #1 cmp(40'(RX_CLK_STOPPED), 40'h0);
      end
      summarize();
   end
   initial begin
      repeat (20000) @(posedge CLK);
      errors++;
      summarize();
   end
endmodule
`default_nettype wire
